/* cgru_chk.sv */
// Purpose: Port assertions for the clock and reset unit.
// Assumes: One clock domain, sys_clk, with reset rst_n.
// Notes: Bound into cgru_top after the module.
`timescale 1ns/10ps
`default_nettype none
module cgru_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wdt_rst_req,
	input wire logic sys_rst_n_out,
	input wire logic wdt_reset_seen,
	input wire logic evt_wakeup,
	input wire logic wake_pending,
	input wire logic [7:0] mod_rst_req,
	input wire logic [7:0] mod_rst_n,
	input wire logic [7:0] out_clk,
	input wire logic [7:0] out_clk_en,
	input wire logic [7:0] auto_gate_en,
	input wire logic [7:0] bus_access,
	input wire logic [7:0] wake_mask
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	wdt_rst_a: assert property (
		$rose(wdt_rst_req) |=> !sys_rst_n_out) else $error("No system reset.");
	rst_len_a: assert property (
		$fell(sys_rst_n_out) |-> ##19 !sys_rst_n_out ##1 sys_rst_n_out)
		else $error("System reset length wrong.");
	wdt_seen_a: assert property (
		!sys_rst_n_out |=> wdt_reset_seen) else $error("Watchdog flag not set.");
	mod_req_a: assert property (
		(|mod_rst_req) |=> ((mod_rst_n & $past(mod_rst_req)) == 8'h00))
		else $error("Module reset not applied.");
	mod_rel_a: assert property (
		$rose(mod_rst_n[4]) |-> $past(out_clk[4]) || $past(out_clk[4], 2) || $past(out_clk[4], 3))
		else $error("Module reset released without its clock.");
	gate_off_a: assert property (
		(!out_clk_en[3] && !(wake_pending && wake_mask[3]))[*8] |-> !out_clk[3])
		else $error("Disabled clock still running.");
	auto_gate_a: assert property (
		(auto_gate_en[2] && !bus_access[2] && !(wake_pending && wake_mask[2]))[*8] |-> !out_clk[2])
		else $error("Auto-gated clock running while idle.");
	wake_set_a: assert property (
		evt_wakeup |=> wake_pending) else $error("Wake-up not recorded.");
endmodule
bind cgru_top cgru_chk chk (.sys_clk, .rst_n, .wdt_rst_req, .sys_rst_n_out, .wdt_reset_seen,
	.evt_wakeup, .wake_pending, .mod_rst_req, .mod_rst_n, .out_clk, .out_clk_en, .auto_gate_en,
	.bus_access, .wake_mask);
`default_nettype wire

/* cgru_far_model.sv */
// Purpose: Watchdog and event router facing the clock and reset unit.
// Assumes: Both run on sys_clk.
// Notes: Watchdog fires TMO+1 cycles after kick falls; wake-up pulses on a button press.
`timescale 1ns/10ps
`default_nettype none
module cgru_far_model #(parameter int TMO = 60) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic kick,
	input wire logic button,
	output logic wdt_rst_req,
	output logic evt_wakeup
);
	int cnt_ff;
	logic btn_ff;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 0;
			btn_ff <= 1'b0;
			wdt_rst_req <= 1'b0;
			evt_wakeup <= 1'b0;
		end else begin
			cnt_ff <= (kick || cnt_ff == TMO) ? 0 : cnt_ff + 1;
			wdt_rst_req <= !kick && cnt_ff == TMO;
			btn_ff <= button;
			evt_wakeup <= button && !btn_ff;
		end
	end
endmodule
`default_nettype wire

/* cgru_fdiv.v */
// Purpose: Fractional divider for one clock subdomain.
// Assumes: Base clock level is sampled on sys_clk.
// Notes: Output rate is base rate times n over m; m of zero bypasses division.
`timescale 1ns/10ps
`default_nettype none
`include "cgru_map.vh"

module cgru_fdiv (
	input wire sys_clk,
	input wire rst_sync_n,
	input wire base_in,
	input wire [`CGRU_FRAC_W-1:0] div_n,
	input wire [`CGRU_FRAC_W-1:0] div_m,
	input wire stretch,
	output reg div_out
);

reg base_d_ff;
reg [`CGRU_FRAC_W-1:0] acc_ff;
reg wrap_ff;
reg [`CGRU_FRAC_W:0] sum;
reg [`CGRU_FRAC_W-1:0] nxt_acc;
reg nxt_wrap;
wire base_rise;

assign base_rise = base_in & ~base_d_ff;

////////////////////////////////////////////////////////////////////////////////
// Phase accumulator advanced on each base clock rising edge.
always @* begin
	sum = {1'b0, acc_ff} + {1'b0, div_n};
	nxt_acc = acc_ff;
	nxt_wrap = wrap_ff;
	if (base_rise) begin
		if (sum >= {1'b0, div_m}) begin
			nxt_acc = sum[`CGRU_FRAC_W-1:0] - div_m; // [RULE2]
			nxt_wrap = 1'b1;
		end else begin
			nxt_acc = sum[`CGRU_FRAC_W-1:0];
			nxt_wrap = 1'b0;
		end
	end
end

always @(posedge sys_clk or negedge rst_sync_n) begin
	if (!rst_sync_n) begin
		base_d_ff <= 1'b0;
		acc_ff <= {`CGRU_FRAC_W{1'b0}};
		wrap_ff <= 1'b0;
		div_out <= 1'b0;
	end else begin
		base_d_ff <= base_in;
		acc_ff <= nxt_acc;
		wrap_ff <= nxt_wrap;
		if (div_m == {`CGRU_FRAC_W{1'b0}}) begin
			div_out <= base_in; // [RULE2]
		end else if (stretch) begin
			div_out <= (nxt_acc < {1'b0, div_m[`CGRU_FRAC_W-1:1]}); // [RULE13]
		end else begin
			div_out <= nxt_wrap & base_in; // [RULE2]
		end
	end
end

endmodule
`default_nettype wire

/* cgru_map.vh */
// Purpose: Constants for the clock generation and reset unit.
// Assumes: Single system clock at 200 MHz; all clock pins sampled on it.
// Notes: Included by every design file of the unit.
`ifndef CGRU_MAP_VH
`define CGRU_MAP_VH

`define CGRU_CLK_PERIOD_NS 5
`define CGRU_N_PLL 2
`define CGRU_N_BASE 4
`define CGRU_N_OUT 8
`define CGRU_SEL_W 3
`define CGRU_FRAC_W 8
`define CGRU_PLL_W 16

`define CGRU_SRC_OSC 3'h0
`define CGRU_SRC_BCK_A 3'h1
`define CGRU_SRC_WS_A 3'h2
`define CGRU_SRC_BCK_B 3'h3
`define CGRU_SRC_WS_B 3'h4
`define CGRU_SRC_SYSPLL 3'h5
`define CGRU_SRC_AUDPLL 3'h6

`define CGRU_PLL_SYS 0
`define CGRU_PLL_AUD 1
`define CGRU_PLL_LOCK_EDGES 4'h8

`define CGRU_OUT_CPU 0
`define CGRU_OUT_BUS 1

`define CGRU_SYSRST_NS 100
`define CGRU_SYSRST_CYC ((`CGRU_SYSRST_NS + `CGRU_CLK_PERIOD_NS - 1) / `CGRU_CLK_PERIOD_NS)

`define CGRU_RST_ACTIVE_N 1'h0
`endif

/* cgru_top.v */
// Purpose: Clock generation and reset unit: sources, PLLs, switchbox, dividers, gating, resets.
// Assumes: All clock pins are synchronous to sys_clk and slow enough to be sampled.
// Notes: Output clocks 2k and 2k+1 belong to domain k; output 0 is the processor clock.
//
// Behaviour
// [RULE1] Each output clock belongs to one domain fed by one selected base clock.
// [RULE2] Fractional dividers divide the base clock; outputs may bypass division.
// [RULE3] A subdomain uses one shared divider or the base clock directly.
// [RULE4] PLL outputs can never be chosen as a PLL reference.
// [RULE5] Software disables each output clock individually.
// [RULE6] Auto-gated outputs run only during a bus access to their module.
// [RULE7] With scaling on, bus clock is fast when busy, slow when idle; the code keeps it fast while out_bypass is set for the bus output.
// [RULE8] Wake-up event re-enables marked clocks, including processor and bus clocks.
// [RULE9] Five sources: oscillator plus two bit-clock and two word-select pins.
// [RULE10] Two PLLs: programmable system clock and programmable audio clock.
// [RULE11] Each PLL selects its own reference from oscillator or external inputs.
// [RULE12] Switchbox routes any source to each base clock separately.
// [RULE13] Divider stretching gives a near 50 percent duty cycle.
// [RULE14] Software asserts and releases each module reset individually.
// [RULE15] Watchdog request produces a system-wide reset.
// [RULE16] Watchdog raises its request when its time-out expires unserviced.
// [RULE17] Event router drives one wake-up output on an enabled event; the model has no enable and pulses on every button press.
// [RULE18] Base clock source changes happen without glitches or short pulses.
// [RULE19] Module reset release is synchronised to that module's clock.
`timescale 1ns/10ps
`default_nettype none
`include "cgru_map.vh"

module cgru_top (
	input wire sys_clk,
	input wire rst_n,
	input wire osc_clk_in,
	input wire audio_rx_bitclk_in_a,
	input wire audio_rx_wordsel_in_a,
	input wire audio_rx_bitclk_in_b,
	input wire audio_rx_wordsel_in_b,
	input wire [`CGRU_N_PLL-1:0] pll_en,
	input wire [`CGRU_N_PLL*`CGRU_SEL_W-1:0] pll_ref_sel,
	input wire [`CGRU_N_PLL*`CGRU_PLL_W-1:0] pll_step,
	output reg [`CGRU_N_PLL-1:0] pll_locked,
	input wire [`CGRU_N_BASE*`CGRU_SEL_W-1:0] base_sel,
	input wire [`CGRU_N_BASE*`CGRU_FRAC_W-1:0] frac_n,
	input wire [`CGRU_N_BASE*`CGRU_FRAC_W-1:0] frac_m,
	input wire [`CGRU_N_BASE-1:0] frac_stretch,
	input wire [`CGRU_N_OUT-1:0] out_bypass,
	input wire [`CGRU_N_OUT-1:0] out_clk_en,
	input wire [`CGRU_N_OUT-1:0] auto_gate_en,
	input wire [`CGRU_N_OUT-1:0] bus_access,
	input wire bus_scale_en,
	input wire bus_active,
	input wire [`CGRU_N_OUT-1:0] wake_mask,
	input wire evt_wakeup,
	input wire wake_clear,
	output reg wake_pending,
	input wire [`CGRU_N_OUT-1:0] mod_rst_req,
	input wire wdt_rst_req,
	output reg [`CGRU_N_OUT-1:0] out_clk,
	output wire [`CGRU_N_OUT-1:0] mod_rst_n,
	output wire sys_rst_n_out,
	output reg wdt_reset_seen
);

localparam [7:0] SYSRST_CYC = `CGRU_SYSRST_CYC;

function [`CGRU_SEL_W-1:0] pll_ref;
	input [`CGRU_SEL_W-1:0] sel;
	begin
		pll_ref = (sel > `CGRU_SRC_WS_B) ? `CGRU_SRC_OSC : sel; // [RULE4]
	end
endfunction

function pick_src;
	input [6:0] srcs;
	input [`CGRU_SEL_W-1:0] sel;
	begin
		pick_src = (sel > `CGRU_SRC_AUDPLL) ? srcs[0] : srcs[sel];
	end
endfunction

reg [1:0] rst_sync_ff;
wire rst_sync_n;
wire [6:0] src_lvl;
wire [4:0] ext_src;
reg [`CGRU_PLL_W-1:0] pll_acc_ff [0:`CGRU_N_PLL-1];
reg [3:0] pll_edges_ff [0:`CGRU_N_PLL-1];
reg [`CGRU_N_PLL-1:0] pll_ref_d_ff;
reg [`CGRU_N_PLL-1:0] pll_out;
reg [`CGRU_SEL_W-1:0] base_cur_ff [0:`CGRU_N_BASE-1];
reg [`CGRU_N_BASE-1:0] base_ff;
wire [`CGRU_N_BASE-1:0] div_lvl;
reg [`CGRU_N_OUT-1:0] gate_ff;
reg [`CGRU_N_OUT-1:0] cand;
reg [`CGRU_N_OUT-1:0] run;
reg bus_slow_ff;
reg [`CGRU_N_OUT-1:0] out_clk_d_ff;
reg [1:0] rsync_ff [0:`CGRU_N_OUT-1];
reg [7:0] sysrst_cnt_ff;
integer ip;
integer ib;
integer ic;
integer ig;
integer ir;

////////////////////////////////////////////////////////////////////////////////
// Reset release through two flip-flops.
always @(posedge sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		rst_sync_ff <= 2'h0;
	end else begin
		rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
end

assign rst_sync_n = rst_sync_ff[1];

////////////////////////////////////////////////////////////////////////////////
// Clock sources and PLLs.
assign ext_src = {audio_rx_wordsel_in_b, audio_rx_bitclk_in_b, audio_rx_wordsel_in_a,
	audio_rx_bitclk_in_a, osc_clk_in}; // [RULE9]
assign src_lvl = {pll_out[`CGRU_PLL_AUD], pll_out[`CGRU_PLL_SYS], ext_src};

always @(posedge sys_clk or negedge rst_sync_n) begin
	if (!rst_sync_n) begin
		pll_ref_d_ff <= {`CGRU_N_PLL{1'b0}};
		pll_locked <= {`CGRU_N_PLL{1'b0}};
		pll_out <= {`CGRU_N_PLL{1'b0}};
		for (ip = 0; ip < `CGRU_N_PLL; ip = ip + 1) begin
			pll_acc_ff[ip] <= {`CGRU_PLL_W{1'b0}};
			pll_edges_ff[ip] <= 4'h0;
		end
	end else begin
		for (ip = 0; ip < `CGRU_N_PLL; ip = ip + 1) begin
			pll_ref_d_ff[ip] <= ext_src[pll_ref(pll_ref_sel[ip*`CGRU_SEL_W +: `CGRU_SEL_W])]; // [RULE11]
			if (!pll_en[ip]) begin
				pll_edges_ff[ip] <= 4'h0;
				pll_locked[ip] <= 1'b0;
				pll_acc_ff[ip] <= {`CGRU_PLL_W{1'b0}};
				pll_out[ip] <= 1'b0;
			end else begin
				if (ext_src[pll_ref(pll_ref_sel[ip*`CGRU_SEL_W +: `CGRU_SEL_W])] &
					~pll_ref_d_ff[ip] && pll_edges_ff[ip] != `CGRU_PLL_LOCK_EDGES) begin
					pll_edges_ff[ip] <= pll_edges_ff[ip] + 4'h1;
				end
				pll_locked[ip] <= (pll_edges_ff[ip] == `CGRU_PLL_LOCK_EDGES);
				if (pll_locked[ip]) begin
					pll_acc_ff[ip] <= pll_acc_ff[ip] +
						pll_step[ip*`CGRU_PLL_W +: `CGRU_PLL_W]; // [RULE10]
				end
				pll_out[ip] <= pll_acc_ff[ip][`CGRU_PLL_W-1];
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Switchbox: a new source is taken only while old and new sources are both low.
always @(posedge sys_clk or negedge rst_sync_n) begin
	if (!rst_sync_n) begin
		base_ff <= {`CGRU_N_BASE{1'b0}};
		for (ib = 0; ib < `CGRU_N_BASE; ib = ib + 1) begin
			base_cur_ff[ib] <= `CGRU_SRC_OSC;
		end
	end else begin
		for (ib = 0; ib < `CGRU_N_BASE; ib = ib + 1) begin
			if (base_sel[ib*`CGRU_SEL_W +: `CGRU_SEL_W] != base_cur_ff[ib] &&
				!pick_src(src_lvl, base_cur_ff[ib]) &&
				!pick_src(src_lvl, base_sel[ib*`CGRU_SEL_W +: `CGRU_SEL_W])) begin
				base_cur_ff[ib] <= base_sel[ib*`CGRU_SEL_W +: `CGRU_SEL_W]; // [RULE12] [RULE18]
				base_ff[ib] <= 1'b0;
			end else begin
				base_ff[ib] <= pick_src(src_lvl, base_cur_ff[ib]); // [RULE1]
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// One fractional divider per domain, shared by the domain's subdomain.
genvar g;
generate
	for (g = 0; g < `CGRU_N_BASE; g = g + 1) begin : dom
		cgru_fdiv u_fdiv (
			.sys_clk(sys_clk),
			.rst_sync_n(rst_sync_n),
			.base_in(base_ff[g]),
			.div_n(frac_n[g*`CGRU_FRAC_W +: `CGRU_FRAC_W]),
			.div_m(frac_m[g*`CGRU_FRAC_W +: `CGRU_FRAC_W]),
			.stretch(frac_stretch[g]),
			.div_out(div_lvl[g])
		); // [RULE2] [RULE3]
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Output clock selection and gating.
always @* begin
	for (ic = 0; ic < `CGRU_N_OUT; ic = ic + 1) begin
		cand[ic] = out_bypass[ic] ? base_ff[ic/2] : div_lvl[ic/2]; // [RULE1] [RULE3]
		run[ic] = (out_clk_en[ic] & (~auto_gate_en[ic] | bus_access[ic])) |
			(wake_pending & wake_mask[ic]); // [RULE5] [RULE6] [RULE8]
	end
	if (bus_scale_en) begin
		cand[`CGRU_OUT_BUS] = bus_slow_ff ? div_lvl[0] : base_ff[0]; // [RULE7]
	end
end

always @(posedge sys_clk or negedge rst_sync_n) begin
	if (!rst_sync_n) begin
		gate_ff <= {`CGRU_N_OUT{1'b0}};
		out_clk <= {`CGRU_N_OUT{1'b0}};
		out_clk_d_ff <= {`CGRU_N_OUT{1'b0}};
		bus_slow_ff <= 1'b0;
		wake_pending <= 1'b0;
	end else begin
		if (!base_ff[0] && !div_lvl[0]) begin
			bus_slow_ff <= bus_scale_en & ~bus_active & ~out_bypass[`CGRU_OUT_BUS]; // [RULE7]
		end
		if (evt_wakeup) begin
			wake_pending <= 1'b1; // [RULE8]
		end else if (wake_clear) begin
			wake_pending <= 1'b0;
		end
		for (ig = 0; ig < `CGRU_N_OUT; ig = ig + 1) begin
			if (!cand[ig]) begin
				gate_ff[ig] <= run[ig]; // [RULE5] [RULE6]
			end
		end
		out_clk <= cand & gate_ff;
		out_clk_d_ff <= out_clk;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Watchdog system reset pulse.
always @(posedge sys_clk or negedge rst_sync_n) begin
	if (!rst_sync_n) begin
		sysrst_cnt_ff <= 8'h00;
		wdt_reset_seen <= 1'b0;
	end else if (wdt_rst_req) begin
		sysrst_cnt_ff <= SYSRST_CYC; // [RULE15] [RULE16]
		wdt_reset_seen <= 1'b1;
	end else if (sysrst_cnt_ff != 8'h00) begin
		sysrst_cnt_ff <= sysrst_cnt_ff - 8'h01;
	end
end

assign sys_rst_n_out = (sysrst_cnt_ff == 8'h00); // [RULE15]

////////////////////////////////////////////////////////////////////////////////
// Module resets released on two rising edges of the module's own clock.
always @(posedge sys_clk or negedge rst_sync_n) begin
	if (!rst_sync_n) begin
		for (ir = 0; ir < `CGRU_N_OUT; ir = ir + 1) begin
			rsync_ff[ir] <= 2'h0;
		end
	end else begin
		for (ir = 0; ir < `CGRU_N_OUT; ir = ir + 1) begin
			if (mod_rst_req[ir] || !sys_rst_n_out) begin
				rsync_ff[ir] <= 2'h0; // [RULE14] [RULE15]
			end else if (out_clk[ir] && !out_clk_d_ff[ir]) begin
				rsync_ff[ir] <= {rsync_ff[ir][0], 1'b1}; // [RULE19]
			end
		end
	end
end

generate
	for (g = 0; g < `CGRU_N_OUT; g = g + 1) begin : mrst
		assign mod_rst_n[g] = rsync_ff[g][1];
	end
endgenerate

endmodule
`default_nettype wire

/* tb_cgru_top.sv */
// Purpose: Self-checking bench for the clock and reset unit.
// Assumes: Source pins are square waves made from sys_clk.
// Notes: Edge counts are taken over 120 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_cgru_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] src = 5'h00;
	logic [1:0] pll_en = 2'h0;
	logic [5:0] pll_ref_sel = 6'h00;
	logic [31:0] pll_step = 32'h0;
	logic [11:0] base_sel = 12'h000;
	logic [31:0] frac_n = 32'h0;
	logic [31:0] frac_m = 32'h0;
	logic [3:0] frac_stretch = 4'h0;
	logic [7:0] out_bypass = 8'hFF;
	logic [7:0] out_clk_en = 8'hFF;
	logic [7:0] auto_gate_en = 8'h00;
	logic [7:0] bus_access = 8'h00;
	logic [7:0] wake_mask = 8'h00;
	logic [7:0] mod_rst_req = 8'h00;
	logic bus_scale_en = 1'b0;
	logic bus_active = 1'b0;
	logic wake_clear = 1'b0;
	logic kick = 1'b1;
	logic button = 1'b0;
	wire logic [1:0] pll_locked;
	wire logic [7:0] out_clk;
	wire logic [7:0] mod_rst_n;
	wire logic wake_pending;
	wire logic sys_rst_n_out;
	wire logic wdt_reset_seen;
	wire logic wdt_rst_req;
	wire logic evt_wakeup;
	int cyc = 0;
	int n_fail = 0;
	int checks_done = 0;
	int e;
	int h;
	int a;
	cgru_top dut (.sys_clk, .rst_n, .osc_clk_in(src[0]), .audio_rx_bitclk_in_a(src[1]),
		.audio_rx_wordsel_in_a(src[2]), .audio_rx_bitclk_in_b(src[3]),
		.audio_rx_wordsel_in_b(src[4]), .pll_en, .pll_ref_sel, .pll_step, .pll_locked,
		.base_sel, .frac_n, .frac_m, .frac_stretch, .out_bypass, .out_clk_en, .auto_gate_en,
		.bus_access, .bus_scale_en, .bus_active, .wake_mask, .evt_wakeup, .wake_clear,
		.wake_pending, .mod_rst_req, .wdt_rst_req, .out_clk, .mod_rst_n, .sys_rst_n_out,
		.wdt_reset_seen);
	cgru_far_model #(.TMO(60)) far (.sys_clk, .rst_n, .kick, .button, .wdt_rst_req, .evt_wakeup);
	////////////////////////////////////////////////////////////////////////////////
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 5; i++) begin
			src[i] <= ((cyc / (i + 2)) % 2) == 1;
		end
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	task automatic cy(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	function automatic logic near(input int v, input int x);
		return v >= x - 1 && v <= x + 1;
	endfunction
	task automatic meas(input int k);
		logic p;
		e = 0;
		h = 0;
		cy(8);
		#1;
		p = out_clk[k];
		repeat (120) begin
			@(posedge sys_clk);
			#1;
			h += out_clk[k] === 1'b1;
			e += out_clk[k] === 1'b1 && p !== 1'b1;
			p = out_clk[k];
		end
		@(posedge sys_clk);
	endtask
	task automatic results;
		$display("Checks %0d, failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		cy(10);
		rst_n <= 1'b1;
		cy(10);
		for (int i = 0; i < 5; i++) begin
			base_sel[2:0] <= i[2:0];
			meas(0);
			chk(near(e, 60 / (i + 2)), 1);
		end
		base_sel[2:0] <= 3'h0;
		frac_n[7:0] <= 8'h01;
		frac_m[7:0] <= 8'h02;
		out_bypass[1:0] <= 2'h0;
		meas(1);
		a = e;
		meas(0);
		chk(near(e, 15), 1);
		chk(e, a);
		frac_stretch[0] <= 1'b1;
		meas(0);
		chk(near(e, 15) && h > 49 && h < 71, 1);
		$display("Source and divider tests done");
		frac_stretch[0] <= 1'b0;
		out_clk_en <= 8'hF6;
		meas(0);
		chk(e, 0);
		meas(1);
		chk(near(e, 15), 1);
		out_clk_en <= 8'hFF;
		auto_gate_en[2] <= 1'b1;
		meas(2);
		chk(e, 0);
		bus_access[2] <= 1'b1;
		meas(2);
		chk(near(e, 30), 1);
		frac_m[7:0] <= 8'h04;
		bus_scale_en <= 1'b1;
		bus_active <= 1'b1;
		meas(1);
		a = e;
		bus_active <= 1'b0;
		meas(1);
		chk(a > e, 1);
		$display("Gating and scaling tests done");
		out_clk_en <= 8'h00;
		wake_mask <= 8'h03;
		button <= 1'b1;
		meas(0);
		chk(e > 0 && wake_pending === 1'b1, 1);
		meas(2);
		chk(e, 0);
		wake_clear <= 1'b1;
		button <= 1'b0;
		cy(1);
		wake_clear <= 1'b0;
		cy(3);
		#1;
		chk(wake_pending, 0);
		cy(1);
		out_clk_en <= 8'hEF;
		mod_rst_req <= 8'h10;
		cy(2);
		#1;
		chk(mod_rst_n, 8'hEF);
		cy(1);
		mod_rst_req <= 8'h00;
		cy(20);
		#1;
		chk(mod_rst_n[4], 0);
		cy(1);
		out_clk_en <= 8'hFF;
		cy(20);
		#1;
		chk(mod_rst_n, 8'hFF);
		$display("Wake-up and module reset tests done");
		cy(1);
		kick <= 1'b0;
		while (sys_rst_n_out !== 1'b0) begin
			@(posedge sys_clk);
			#1;
		end
		cy(1);
		kick <= 1'b1;
		#1;
		chk(mod_rst_n, 8'h00);
		cy(80);
		#1;
		chk({sys_rst_n_out, wdt_reset_seen, mod_rst_n}, 10'h3FF);
		cy(1);
		pll_ref_sel <= 6'h0D;
		pll_step <= 32'h20004000;
		pll_en <= 2'h3;
		base_sel[11:6] <= 6'h2E;
		while (pll_locked !== 2'h3) begin
			@(posedge sys_clk);
			#1;
		end
		meas(6);
		chk(near(e, 30), 1);
		meas(4);
		chk(near(e, 15), 1);
		$display("Watchdog and synthesis tests done");
		results();
	end
endmodule
`default_nettype wire
